// file: dv/tb_top.sv
/*
 * self-checking bench for the host interrupt status unit: register
 * read/write tasks, event pulses and directed flag scenarios.
 * assumes his_pkg and his_unit are compiled first; one 10 MHz clock.
 */
`timescale 1ns/10ps
module tb_top;
   // ************************************************
   // signals and register addresses
   // ************************************************
   localparam logic [11:0] EN = his_pkg::HIS_ENABLE_OFS;
   localparam logic [11:0] ST = his_pkg::HIS_STATUS_OFS;
   localparam logic [11:0] TH = his_pkg::HIS_THRESH_OFS;
   logic        core_clk, nrst, reg_wr, reg_rd, pm_wr, irq;
   logic [11:0] reg_addr, ev, ts_ready, ts_enable, trig_event, trig_enable;
   logic [15:0] reg_wdata, reg_rdata;
   logic [3:0]  pm_code;
   logic [7:0]  rx_frame_cnt, rx_threshold;
   logic [1:0]  egress_ts;
   int          n_fail, n_checks;
   int          sb [1:10] = '{2, 3, 4, 5, 6, 8, 9, 11, 13, 14};

   his_unit i_his_unit (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pm_wr(pm_wr), .pm_code(pm_code), .evt(his_pkg::his_evt_t'(ev)),
      .rx_frame_cnt(rx_frame_cnt), .ts_ready(ts_ready), .ts_enable(ts_enable),
      .egress_ts(egress_ts), .trig_event(trig_event), .trig_enable(trig_enable),
      .irq(irq), .rx_threshold(rx_threshold));

   // ************************************************
   // clock and watchdog
   // ************************************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      test_done;
   end

   // ************************************************
   // access tasks
   // ************************************************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string nm);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(nm, exp, reg_rdata);
   endtask
   task automatic pm(input logic [3:0] c);
      @(posedge core_clk);
      pm_wr   <= 1'b1;
      pm_code <= c;
      @(posedge core_clk);
      pm_wr <= 1'b0;
   endtask
   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask
   // flag b seen and on the pin, cleared by its own means, then gone
   task automatic flag(input int b);
      rd(ST, 16'h0001 << b, "status set");
      chk("irq set", 16'h0001, {15'h0000, irq});
      rd(ST, 16'h0001 << b, "status after read");
      if (b > 1 && b < 6) begin
         wr(ST, 16'hFFFF);
         pm(4'hF);
         rd(ST, 16'h0001 << b, "wake flag held");
         pm(4'h1 << (b - 2));
      end else begin
         wr(ST, 16'h0001 << b);
      end
      rd(ST, 16'h0000, "status clear");
      chk("irq clear", 16'h0000, {15'h0000, irq});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ************************************************
   // directed scenarios
   // ************************************************
   initial begin
      {nrst, reg_wr, reg_rd, pm_wr, reg_addr, reg_wdata, pm_code} = '0;
      {ev, rx_frame_cnt, ts_ready, ts_enable, egress_ts, trig_event, trig_enable} = '0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      rd(EN, 16'h0000, "enable reset");
      rd(ST, 16'h0000, "status reset");
      rd(TH, 16'h0000, "threshold reset");
      wr(EN, 16'hFF7F);
      rd(EN, 16'hEB7C, "enable write");
      @(posedge core_clk);
      ts_enable <= 12'h800;
      rd(EN, 16'hFB7C, "timestamp enable or");
      @(posedge core_clk);
      trig_enable <= 12'h001;
      rd(EN, 16'hFF7C, "trigger enable or");
      // a masked flag reaches the pin only once enabled
      wr(EN, 16'h0000);
      pulse(8);
      rd(ST, 16'h0800, "overrun latched");
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(EN, 16'hFF7F);
      flag(11);
      // link change in both directions
      @(posedge core_clk);
      ev[11] <= 1'b1;
      flag(15);
      @(posedge core_clk);
      ev[11] <= 1'b0;
      flag(15);
      for (int i = 1; i <= 10; i++) begin
         pulse(i);
         flag(sb[i]);
      end
      @(posedge core_clk);
      ts_ready <= 12'h020;
      flag(12);
      @(posedge core_clk);
      egress_ts <= 2'b10;
      flag(12);
      @(posedge core_clk);
      trig_event <= 12'h800;
      flag(10);
      wr(ST, 16'hFFFF);
      rd(ST, 16'h0000, "reserved status");
      wr(12'h194, 16'hFFFF);
      rd(12'h194, 16'h0000, "unmapped read");
      rd(EN, 16'hFF7C, "enable kept");
      // frame-count threshold mode
      wr(TH, 16'h0003);
      rd(TH, 16'h0003, "threshold readback");
      chk("threshold out", 16'h0003, {8'h00, rx_threshold});
      @(posedge core_clk);
      ev[0]        <= 1'b1;
      rx_frame_cnt <= 8'h03;
      pulse(9);
      rd(ST, 16'h0000, "count at threshold");
      @(posedge core_clk);
      rx_frame_cnt <= 8'h04;
      flag(13);
      test_done;
   end
endmodule

// file: src/his_pkg.sv
/*
 * package for the host interrupt status unit: register offsets, field
 * positions, reset values and the packed state record.
 * assumes a 16-bit register port with byte addresses as printed.
 */
package his_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [11:0] HIS_ENABLE_OFS    = 12'h190;
   localparam logic [11:0] HIS_STATUS_OFS    = 12'h192;
   localparam logic [11:0] HIS_THRESH_OFS    = 12'h19C;
   localparam logic [15:0] HIS_ENABLE_RST    = 16'h0000;
   localparam logic [15:0] HIS_STATUS_RST    = 16'h0000;
   localparam logic [15:0] HIS_THRESH_RST    = 16'h0000;
   // ****************************************************************
   // status bit positions
   // ****************************************************************
   localparam int HIS_LINK_BIT    = 15;
   localparam int HIS_TXDONE_BIT  = 14;
   localparam int HIS_RXRDY_BIT   = 13;
   localparam int HIS_TSTAMP_BIT  = 12;
   localparam int HIS_OVRUN_BIT   = 11;
   localparam int HIS_TRIG_BIT    = 10;
   localparam int HIS_TXSTOP_BIT  = 9;
   localparam int HIS_RXSTOP_BIT  = 8;
   localparam int HIS_TXSPACE_BIT = 6;
   localparam int HIS_WFRAME_BIT  = 5;
   localparam int HIS_WREMOTE_BIT = 4;
   localparam int HIS_WLINK_BIT   = 3;
   localparam int HIS_WENERGY_BIT = 2;
   // write-one-clearable flags
   localparam logic [15:0] HIS_W1C_MASK  = 16'hFF40;
   // wake flags, cleared through power management
   localparam logic [15:0] HIS_WAKE_MASK = 16'h003C;
   // enable bits software may write (12 and 10 are derived)
   localparam logic [15:0] HIS_EN_WMASK  = 16'hEBFC;
   localparam int HIS_THRESH_W = 8;
   // power management clear codes in field 5:2
   localparam logic [3:0] HIS_PM_CLR_WFRAME  = 4'h8;
   localparam logic [3:0] HIS_PM_CLR_WREMOTE = 4'h4;
   localparam logic [3:0] HIS_PM_CLR_WLINK   = 4'h2;
   localparam logic [3:0] HIS_PM_CLR_WENERGY = 4'h1;

   // raw event inputs
   typedef struct packed {
      logic link_up;
      logic tx_done;
      logic rx_frame;
      logic rx_overrun;
      logic tx_stopped;
      logic rx_stopped;
      logic tx_space;
      logic wake_frame;
      logic wake_remote;
      logic wake_link;
      logic wake_energy;
      logic rx_thresh_en;
   } his_evt_t;

   // whole state of the unit
   typedef struct packed {
      logic [15:0] status;
      logic [15:0] enable;
      logic [7:0]  thresh;
      logic        link_q;
      logic [11:0] ts_q;
      logic [11:0] trig_q;
      logic [1:0]  egr_q;
      logic        rxthr_q;
      logic        irq;
      logic [15:0] rdata;
   } his_state_t;
endpackage

// file: src/his_unit.sv
/*
 * host interrupt status unit: latches events into the status register,
 * gates them with the enable register onto the interrupt pin, and holds
 * the receive frame-count threshold.
 * assumes events are synchronous to core_clk and the frame count comes
 * from the queue manager; register port is 16-bit with read/write strobes.
 */
`timescale 1ns/10ps
module his_unit #(
   parameter int TS_UNITS   = 12,
   parameter int TRIG_UNITS = 12
) (
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic [11:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [15:0]           reg_wdata,
   output logic      [15:0]           reg_rdata,
   input  wire logic                  pm_wr,
   input  wire logic [3:0]            pm_code,
   input  wire his_pkg::his_evt_t     evt,
   input  wire logic [7:0]            rx_frame_cnt,
   input  wire logic [TS_UNITS-1:0]   ts_ready,
   input  wire logic [TS_UNITS-1:0]   ts_enable,
   input  wire logic [1:0]            egress_ts,
   input  wire logic [TRIG_UNITS-1:0] trig_event,
   input  wire logic [TRIG_UNITS-1:0] trig_enable,
   output logic                       irq,
   output logic      [7:0]            rx_threshold
);
   // ****************************************************************
   // state
   // ****************************************************************
   his_pkg::his_state_t s_r, s_nxt;
   logic [15:0] set_v;
   logic [15:0] w1c_v;
   logic [15:0] pm_v;
   logic [15:0] en_v;
   logic        wr_stat, wr_en, wr_thr, rxthr_now;

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      s_nxt     = s_r;
      wr_stat   = 1'b0;
      wr_en     = 1'b0;
      wr_thr    = 1'b0;
      // address decode
      if (reg_addr == his_pkg::HIS_STATUS_OFS) begin
         wr_stat = reg_wr;
      end else if (reg_addr == his_pkg::HIS_ENABLE_OFS) begin
         wr_en = reg_wr;
      end else if (reg_addr == his_pkg::HIS_THRESH_OFS) begin
         wr_thr = reg_wr;
      end
      rxthr_now = evt.rx_thresh_en && (s_r.thresh != 8'h00)
                  && (rx_frame_cnt > s_r.thresh);
      // event detection: link on change, timestamp/trigger/threshold on rising edge, rest on level
      set_v = 16'h0000;
      set_v[his_pkg::HIS_LINK_BIT]    = evt.link_up != s_r.link_q;
      set_v[his_pkg::HIS_TXDONE_BIT]  = evt.tx_done;
      set_v[his_pkg::HIS_RXRDY_BIT]   = (evt.rx_frame && !evt.rx_thresh_en)
                                        || (rxthr_now && !s_r.rxthr_q);
      set_v[his_pkg::HIS_TSTAMP_BIT]  = |(ts_ready & ~s_r.ts_q)
                                        || |(egress_ts & ~s_r.egr_q);
      set_v[his_pkg::HIS_OVRUN_BIT]   = evt.rx_overrun;
      set_v[his_pkg::HIS_TRIG_BIT]    = |(trig_event & ~s_r.trig_q);
      set_v[his_pkg::HIS_TXSTOP_BIT]  = evt.tx_stopped;
      set_v[his_pkg::HIS_RXSTOP_BIT]  = evt.rx_stopped;
      set_v[his_pkg::HIS_TXSPACE_BIT] = evt.tx_space;
      set_v[his_pkg::HIS_WFRAME_BIT]  = evt.wake_frame;
      set_v[his_pkg::HIS_WREMOTE_BIT] = evt.wake_remote;
      set_v[his_pkg::HIS_WLINK_BIT]   = evt.wake_link;
      set_v[his_pkg::HIS_WENERGY_BIT] = evt.wake_energy;
      // host clears: write one on w1c bits, reads have no effect
      w1c_v = wr_stat ? (reg_wdata & his_pkg::HIS_W1C_MASK) : 16'h0000;
      pm_v  = 16'h0000;
      pm_v[his_pkg::HIS_WFRAME_BIT]  = pm_wr && pm_code == his_pkg::HIS_PM_CLR_WFRAME;
      pm_v[his_pkg::HIS_WREMOTE_BIT] = pm_wr && pm_code == his_pkg::HIS_PM_CLR_WREMOTE;
      pm_v[his_pkg::HIS_WLINK_BIT]   = pm_wr && pm_code == his_pkg::HIS_PM_CLR_WLINK;
      pm_v[his_pkg::HIS_WENERGY_BIT] = pm_wr && pm_code == his_pkg::HIS_PM_CLR_WENERGY;
      // set wins over a same-cycle clear; reserved bits stay zero
      s_nxt.status = ((s_r.status & ~(w1c_v | pm_v)) | set_v)
                     & (his_pkg::HIS_W1C_MASK | his_pkg::HIS_WAKE_MASK);
      if (wr_en) begin
         s_nxt.enable = reg_wdata & his_pkg::HIS_EN_WMASK;
      end
      if (wr_thr) begin
         s_nxt.thresh = reg_wdata[his_pkg::HIS_THRESH_W-1:0];
      end
      // derived enable bits; next enable so the pin follows an enable write at once
      en_v = s_nxt.enable;
      en_v[his_pkg::HIS_TSTAMP_BIT] = |ts_enable;
      en_v[his_pkg::HIS_TRIG_BIT]   = |trig_enable;
      s_nxt.link_q  = evt.link_up;
      s_nxt.ts_q    = ts_ready;
      s_nxt.trig_q  = trig_event;
      s_nxt.egr_q   = egress_ts;
      s_nxt.rxthr_q = rxthr_now;
      s_nxt.irq     = |(s_nxt.status & en_v);
      // registered read data
      if (!reg_rd) begin
         s_nxt.rdata = 16'h0000;
      end else if (reg_addr == his_pkg::HIS_STATUS_OFS) begin
         s_nxt.rdata = s_r.status;
      end else if (reg_addr == his_pkg::HIS_ENABLE_OFS) begin
         s_nxt.rdata = en_v;
      end else if (reg_addr == his_pkg::HIS_THRESH_OFS) begin
         s_nxt.rdata = {8'h00, s_r.thresh};
      end else begin
         s_nxt.rdata = 16'h0000;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{status: his_pkg::HIS_STATUS_RST, enable: his_pkg::HIS_ENABLE_RST,
                  thresh: his_pkg::HIS_THRESH_RST[7:0], default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   assign irq          = s_r.irq;
   assign reg_rdata    = s_r.rdata;
   assign rx_threshold = s_r.thresh;

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence seq_clear_w1c(int b);
      reg_wr && reg_addr == his_pkg::HIS_STATUS_OFS && reg_wdata[b];
   endsequence

   // power code write of one exact value
   sequence seq_pm_code(logic [3:0] c);
      pm_wr && pm_code == c;
   endsequence

   // frame count climbs above a nonzero threshold while threshold mode is on
   sequence seq_count_rise;
      !(evt.rx_thresh_en && rx_threshold != 8'h00 && rx_frame_cnt > rx_threshold)
      ##1 (evt.rx_thresh_en && rx_threshold != 8'h00 && rx_frame_cnt > rx_threshold);
   endsequence

   // pin follows enabled flags in the same cycle
   AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (!nrst)
      (s_r.status & s_r.enable) != 16'h0000 |-> irq)
      else $error("interrupt not raised for enabled flag");

   // pin only raised by an enabled flag
   AST_IRQ_ONLY_ENABLED: assert property (@(posedge core_clk) disable iff (!nrst)
      irq |-> (s_r.status & s_r.enable) != 16'h0000
              || (s_r.status[his_pkg::HIS_TSTAMP_BIT] && $past(|ts_enable))
              || (s_r.status[his_pkg::HIS_TRIG_BIT] && $past(|trig_enable)))
      else $error("interrupt raised without enabled flag");

   // no flag falls without a write
   AST_READ_KEEPS: assert property (@(posedge core_clk) disable iff (!nrst)
      !reg_wr && !pm_wr |=> ($past(s_r.status) & ~s_r.status) == 16'h0000)
      else $error("status changed without write");

   // status writes never touch the wake flags
   AST_STATUS_WR_WAKE: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_wr && reg_addr == his_pkg::HIS_STATUS_OFS && !pm_wr
      |=> ($past(s_r.status) & his_pkg::HIS_WAKE_MASK & ~s_r.status) == 16'h0000)
      else $error("wake flag cleared by status write");

   AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      s_r.status[his_pkg::HIS_LINK_BIT] && !(reg_wr && reg_addr == his_pkg::HIS_STATUS_OFS)
      |=> s_r.status[his_pkg::HIS_LINK_BIT])
      else $error("link flag dropped without clear");
   AST_LINK_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.link_up != s_r.link_q |=> s_r.status[his_pkg::HIS_LINK_BIT])
      else $error("link change not latched");

   // transmit done latches
   AST_TXDONE_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.tx_done |=> s_r.status[his_pkg::HIS_TXDONE_BIT])
      else $error("transmit done not latched");

   // received frame latches outside threshold mode
   AST_RXRDY_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.rx_frame && !evt.rx_thresh_en |=> s_r.status[his_pkg::HIS_RXRDY_BIT])
      else $error("receive ready not latched");

   // any timestamp or egress rising edge latches
   AST_TSTAMP_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      (ts_ready & ~$past(ts_ready)) != '0 || (egress_ts & ~$past(egress_ts)) != 2'b00
      |=> s_r.status[his_pkg::HIS_TSTAMP_BIT])
      else $error("timestamp event not latched");

   // any trigger unit rising edge latches
   AST_TRIG_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      (trig_event & ~$past(trig_event)) != '0 |=> s_r.status[his_pkg::HIS_TRIG_BIT])
      else $error("trigger event not latched");

   // process stops latch
   AST_TXSTOP_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.tx_stopped |=> s_r.status[his_pkg::HIS_TXSTOP_BIT])
      else $error("transmit stop not latched");
   AST_RXSTOP_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.rx_stopped |=> s_r.status[his_pkg::HIS_RXSTOP_BIT])
      else $error("receive stop not latched");

   // transmit space latches
   AST_TXSPACE_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.tx_space |=> s_r.status[his_pkg::HIS_TXSPACE_BIT])
      else $error("transmit space not latched");

   // wake events latch into bits 5 to 2
   AST_WAKE_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      {evt.wake_frame, evt.wake_remote, evt.wake_link, evt.wake_energy} != 4'h0
      |=> (s_r.status[5:2] & $past({evt.wake_frame, evt.wake_remote, evt.wake_link,
                                     evt.wake_energy}))
          == $past({evt.wake_frame, evt.wake_remote, evt.wake_link, evt.wake_energy}))
      else $error("wake event not latched");

   // remote wake flag held unless its own code is written
   AST_REMOTE_HELD: assert property (@(posedge core_clk) disable iff (!nrst)
      s_r.status[his_pkg::HIS_WREMOTE_BIT]
      && !(pm_wr && pm_code == his_pkg::HIS_PM_CLR_WREMOTE)
      |=> s_r.status[his_pkg::HIS_WREMOTE_BIT])
      else $error("remote wake flag cleared without its code");

   // wake frame and link-up wake flags cleared by their codes
   AST_WAKE_FRAME_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_pm_code(his_pkg::HIS_PM_CLR_WFRAME) ##0 !evt.wake_frame
      |=> !s_r.status[his_pkg::HIS_WFRAME_BIT])
      else $error("wake frame flag not cleared");
   AST_LINKWAKE_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_pm_code(his_pkg::HIS_PM_CLR_WLINK) ##0 !evt.wake_link
      |=> !s_r.status[his_pkg::HIS_WLINK_BIT])
      else $error("link-up wake flag not cleared");

   // threshold crossing latches the receive flag
   AST_THRESH_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_count_rise |=> s_r.status[his_pkg::HIS_RXRDY_BIT])
      else $error("threshold crossing not latched");

   // threshold write lands on the output
   AST_THRESH_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_wr && reg_addr == his_pkg::HIS_THRESH_OFS
      |=> rx_threshold == $past(reg_wdata[7:0]))
      else $error("threshold write lost");

   // enable write lands with derived bits 12 and 10 and reserved bits 1:0 masked; reserved bit 7 is kept
   AST_EN_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_wr && reg_addr == his_pkg::HIS_ENABLE_OFS
      |=> s_r.enable == ($past(reg_wdata) & his_pkg::HIS_EN_WMASK))
      else $error("enable write wrong");

   AST_OVRUN_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      evt.rx_overrun |=> s_r.status[11])
      else $error("overrun not latched");
   AST_W1C_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_clear_w1c(his_pkg::HIS_TXSPACE_BIT) ##0 !evt.tx_space
      |=> !s_r.status[his_pkg::HIS_TXSPACE_BIT])
      else $error("transmit space flag not cleared");
   AST_WAKE_W1C_IGNORED: assert property (@(posedge core_clk) disable iff (!nrst)
      s_r.status[5] && !pm_wr |=> s_r.status[5])
      else $error("wake frame flag cleared without power code");
   AST_WAKE_PM_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      pm_wr && pm_code == 4'h1 && !evt.wake_energy |=> !s_r.status[2])
      else $error("energy wake flag not cleared");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
      (s_r.status & 16'h0083) == 16'h0000)
      else $error("reserved status bit set");
   AST_EN_DERIVED: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == his_pkg::HIS_ENABLE_OFS
      |=> reg_rdata[10] == $past(|trig_enable) && reg_rdata[12] == $past(|ts_enable))
      else $error("derived enable bits wrong");
endmodule
